// ==== hdl/sea_pkg.sv ====
// Package: constants for the management interrupt and wake event aggregator
package sea_pkg;
  // Source counts
  localparam int SEA_NUM_PERIPH = 7;   // Peripheral function sources
  localparam int SEA_NUM_EDGE   = 21;  // GPIO plus fan tach edge sources for the interrupt
  localparam int SEA_NUM_WAKE   = 33;  // GPIO plus fan tach edge sources for wake
  localparam int SEA_NUM_MISC   = 4;   // Ring one, ring two, infrared frame, keyboard/mouse
  // Peripheral index of the infrared event
  localparam int SEA_IR_IDX     = 6;
  // GPIO control register field positions
  localparam int SEA_CTRL_POL   = 1;   // Polarity bit: 1 inverts
  localparam int SEA_CTRL_BUF   = 7;   // Buffer type: 1 push-pull, 0 open-drain
  // Second SMI enable register field positions
  localparam int SEA_EN2_PIN    = 7;
  localparam int SEA_EN2_SIRQ   = 6;
  localparam int SEA_EN2_WAKE   = 5;
  // Routed bit position in the third wake status and enable registers
  localparam int SEA_ROUTE_BIT  = 3;
  // Reset value of output pin control: active low, open-drain
  localparam logic [7:0] SEA_PIN_CTRL_RST = 8'h00;
endpackage : sea_pkg

// ==== hdl/sea_edge_detect.sv ====
// Edge detector with pin synchroniser for one group of event inputs
`timescale 1ns/1ps
module sea_edge_detect #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  // Pin side
  input  wire logic [WIDTH-1:0] pinIn,
  input  wire logic [WIDTH-1:0] invert,
  input  wire logic [WIDTH-1:0] bothEdges,
  // Event pulses
  output logic      [WIDTH-1:0] hit
);
  import sea_pkg::*;

  logic [WIDTH-1:0] meta_reg, meta_next;
  logic [WIDTH-1:0] sync_reg, sync_next;
  logic [WIDTH-1:0] last_reg, last_next;
  logic [1:0]       fill_reg, fill_next;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_next = pinIn;
    sync_next = meta_reg;
    last_next = sync_reg;
    // Pipeline fill: a pin idling high must not look like an edge after reset
    fill_next = (fill_reg == 2'h3) ? fill_reg : fill_reg + 2'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
      fill_reg <= 2'h0;
    end
    else if (clkEn)
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
      fill_reg <= fill_next;
    end
  end

  // Per bit edge selection; the dual edge mode ignores polarity
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gEdge
      always_comb
      begin
        if (fill_reg != 2'h3)
          hit[g] = 1'b0;
        else if (bothEdges[g])
          hit[g] = clkEn & (sync_reg[g] ^ last_reg[g]);
        else if (invert[g])
          hit[g] = clkEn & last_reg[g] & ~sync_reg[g];
        else
          hit[g] = clkEn & ~last_reg[g] & sync_reg[g];
      end
    end
  endgenerate
endmodule : sea_edge_detect

// ==== hdl/sea_smi_pme_aggregator.sv ====
// Grouped management interrupt and wake event aggregator
`timescale 1ns/1ps
// Summary of operation
// - Grouped interrupt is OR of all enabled peripheral, GPIO and tach sources
// - Interrupt pin active level follows its GPIO control polarity bit
// - Interrupt pin driver is open-drain or push-pull by control bit 7
// - Both output pins default to active low open-drain after reset
// - Grouped interrupt reaches its pin only when enable two bit 7 set
// - Enable two bit 6 also signals the interrupt in the serial IRQ2 slot
// - Enable two bit 5 feeds the grouped interrupt into the wake logic
// - GPIO and tach interrupt status set on edge chosen by polarity, rising default
// - Dual edge GPIOs set interrupt status on both edges
// - GPIO interrupt status clears only on a written one
// - Latched GPIO and tach status ANDed with enable feed the group
// - Peripheral status follows source; infrared clears on status two read
// - Peripheral raw events other than infrared ANDed directly with enables, no latching
// - Ring, infrared, keyboard, mouse, GPIO and tach edges raise wake events
// - Wake pin active level follows its GPIO control polarity bit
// - Wake pin driver is open-drain or push-pull by control bit 7
// - Wake output never asserts with global enable clear, else enabled sources assert
// - Global wake status sets on enabled source edges regardless of global enable
// - Global wake status holds while any enabled event status bit is set
// - GPIO wake edges follow polarity, rising default, dual edge sets both
// - GPIO wake status clears on a written one
// - Wake status and enable include a fan tachometer bit
// - Routed interrupt wake status reflects group when routed, clears on written one
// - Routed enable with routed status asserts the wake pin while global wake enable is set
module sea_smi_pme_aggregator (
  // Clock, reset and enable
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               clkEn,
  // Peripheral function interrupt sources and enables
  input  wire logic [sea_pkg::SEA_NUM_PERIPH-1:0] periphIrq,
  input  wire logic [sea_pkg::SEA_NUM_PERIPH-1:0] periphIrqEnable,
  input  wire logic                               deviceIrqStatusTwoRead,
  // GPIO and tach interrupt edge sources
  input  wire logic [sea_pkg::SEA_NUM_EDGE-1:0]   irqEdgePin,
  input  wire logic [sea_pkg::SEA_NUM_EDGE-1:0]   irqEdgeInvert,
  input  wire logic [sea_pkg::SEA_NUM_EDGE-1:0]   irqDualEdgeEvent,
  input  wire logic [sea_pkg::SEA_NUM_EDGE-1:0]   irqEdgeEnable,
  input  wire logic [sea_pkg::SEA_NUM_EDGE-1:0]   irqEdgeStatusClear,
  // Second SMI enable register
  input  wire logic [7:0]                         irqEnableTwo,
  // Wake sources: GPIO and tach edges
  input  wire logic [sea_pkg::SEA_NUM_WAKE-1:0]   wakeEdgePin,
  input  wire logic [sea_pkg::SEA_NUM_WAKE-1:0]   wakeEdgeInvert,
  input  wire logic [sea_pkg::SEA_NUM_WAKE-1:0]   wakeDualEdgeEvent,
  input  wire logic [sea_pkg::SEA_NUM_WAKE-1:0]   wakeEdgeEnable,
  input  wire logic [sea_pkg::SEA_NUM_WAKE-1:0]   wakeEdgeStatusClear,
  // Wake sources: ring indicators, infrared, keyboard/mouse (event pulses)
  input  wire logic [sea_pkg::SEA_NUM_MISC-1:0]   wakeMiscEvent,
  input  wire logic [sea_pkg::SEA_NUM_MISC-1:0]   wakeMiscEnable,
  input  wire logic [sea_pkg::SEA_NUM_MISC-1:0]   wakeMiscStatusClear,
  // Global wake and routed interrupt control
  input  wire logic                               globalWakeEnable,
  input  wire logic                               routedIrqWakeEnable,
  input  wire logic                               routedIrqWakeStatusClear,
  // Output pin GPIO control registers
  input  wire logic [7:0]                         irqPinGpioCtrl,
  input  wire logic [7:0]                         wakePinGpioCtrl,
  // Status views
  output logic      [sea_pkg::SEA_NUM_PERIPH-1:0] periphIrqStatus,
  output logic      [sea_pkg::SEA_NUM_EDGE-1:0]   irqEdgeStatus,
  output logic      [sea_pkg::SEA_NUM_WAKE-1:0]   wakeEdgeStatus,
  output logic      [sea_pkg::SEA_NUM_MISC-1:0]   wakeMiscStatus,
  output logic                                    globalWakeStatus,
  output logic                                    routedIrqWakeStatus,
  output logic                                    groupedMgmtIrq,
  output logic                                    serialIrq2,
  // Pins
  output logic                                    mgmtIrqPinOut,
  output logic                                    mgmtIrqPinOe,
  output logic                                    wakeEventPinOut,
  output logic                                    wakeEventPinOe
);
  import sea_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  logic [SEA_NUM_EDGE-1:0] irqHit;
  logic [SEA_NUM_WAKE-1:0] wakeHit;

  // Polarity selects the edge, dual edge overrides it
  sea_edge_detect #(.WIDTH(SEA_NUM_EDGE)) uIrqEdge (
    .clk       (clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .pinIn     (irqEdgePin),
    .invert    (irqEdgeInvert),
    .bothEdges (irqDualEdgeEvent),
    .hit       (irqHit)
  );

  sea_edge_detect #(.WIDTH(SEA_NUM_WAKE)) uWakeEdge (
    .clk       (clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .pinIn     (wakeEdgePin),
    .invert    (wakeEdgeInvert),
    .bothEdges (wakeDualEdgeEvent),
    .hit       (wakeHit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt side state

  logic [SEA_NUM_PERIPH-1:0] pStat_reg, pStat_next;
  logic [SEA_NUM_EDGE-1:0]   eStat_reg, eStat_next;
  logic                      irRaw_reg, irRaw_next;
  logic                      group_reg, group_next;
  logic                      sirq_reg,  sirq_next;
  logic                      groupComb;
  logic [SEA_NUM_PERIPH-1:0] periphView;

  // Infrared status is sticky until status two is read; a new rising edge
  // in the read cycle wins so the event is not lost.
  always_comb
  begin
    periphView = periphIrq;
    irRaw_next = periphIrq[SEA_IR_IDX];
    pStat_next = periphIrq;
    pStat_next[SEA_IR_IDX] = (pStat_reg[SEA_IR_IDX] & ~deviceIrqStatusTwoRead)
                           | (periphIrq[SEA_IR_IDX] & ~irRaw_reg);
    periphView[SEA_IR_IDX] = pStat_reg[SEA_IR_IDX];
    // Set wins over a write of one; a write of zero has no effect
    eStat_next = (eStat_reg & ~irqEdgeStatusClear) | irqHit;
    groupComb  = |(periphView & periphIrqEnable)
               | |(eStat_reg & irqEdgeEnable);
    group_next = groupComb;
    sirq_next  = groupComb & irqEnableTwo[SEA_EN2_SIRQ];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pStat_reg <= '0;
      eStat_reg <= '0;
      irRaw_reg <= 1'b0;
      group_reg <= 1'b0;
      sirq_reg  <= 1'b0;
    end
    else if (clkEn)
    begin
      pStat_reg <= pStat_next;
      eStat_reg <= eStat_next;
      irRaw_reg <= irRaw_next;
      group_reg <= group_next;
      sirq_reg  <= sirq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake side state

  logic [SEA_NUM_WAKE-1:0] wStat_reg, wStat_next;
  logic [SEA_NUM_MISC-1:0] mStat_reg, mStat_next;
  logic                    route_reg, route_next;
  logic                    gStat_reg, gStat_next;
  logic                    pend;

  // Status bits are set regardless of enables; clear is write-one
  always_comb
  begin
    wStat_next = (wStat_reg & ~wakeEdgeStatusClear) | wakeHit;
    mStat_next = (mStat_reg & ~wakeMiscStatusClear) | wakeMiscEvent;
    // Routed status latches the group only while routing is enabled
    route_next = (route_reg & ~routedIrqWakeStatusClear)
               | (groupComb & irqEnableTwo[SEA_EN2_WAKE]);
    // Global status is the OR of enabled pending events, independent of the
    // global enable; it drops once no enabled pending bit remains.
    pend       = |(wStat_next & wakeEdgeEnable)
               | |(mStat_next & wakeMiscEnable)
               | (route_next & routedIrqWakeEnable);
    gStat_next = pend;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wStat_reg <= '0;
      mStat_reg <= '0;
      route_reg <= 1'b0;
      gStat_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      wStat_reg <= wStat_next;
      mStat_reg <= mStat_next;
      route_reg <= route_next;
      gStat_reg <= gStat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  logic irqPinOut_reg, irqPinOut_next;
  logic irqPinOe_reg,  irqPinOe_next;
  logic wakPinOut_reg, wakPinOut_next;
  logic wakPinOe_reg,  wakPinOe_next;
  logic irqActive, wakActive;

  // Active level is the control polarity: clear gives active low. Open-drain
  // only ever drives low, so an active-high open-drain pin relies on the pullup.
  always_comb
  begin
    irqActive      = groupComb & irqEnableTwo[SEA_EN2_PIN];
    wakActive      = globalWakeEnable & pend;
    irqPinOut_next = ~(irqActive ^ irqPinGpioCtrl[SEA_CTRL_POL]);
    wakPinOut_next = ~(wakActive ^ wakePinGpioCtrl[SEA_CTRL_POL]);
    irqPinOe_next  = irqPinGpioCtrl[SEA_CTRL_BUF] | ~irqPinOut_next;
    wakPinOe_next  = wakePinGpioCtrl[SEA_CTRL_BUF] | ~wakPinOut_next;
  end

  // Reset leaves both pins released: active low open-drain, inactive
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqPinOut_reg <= ~SEA_PIN_CTRL_RST[SEA_CTRL_POL];
      irqPinOe_reg  <= SEA_PIN_CTRL_RST[SEA_CTRL_BUF];
      wakPinOut_reg <= ~SEA_PIN_CTRL_RST[SEA_CTRL_POL];
      wakPinOe_reg  <= SEA_PIN_CTRL_RST[SEA_CTRL_BUF];
    end
    else if (clkEn)
    begin
      irqPinOut_reg <= irqPinOut_next;
      irqPinOe_reg  <= irqPinOe_next;
      wakPinOut_reg <= wakPinOut_next;
      wakPinOe_reg  <= wakPinOe_next;
    end
  end

  // Outputs straight from flip-flops
  assign periphIrqStatus     = pStat_reg;
  assign irqEdgeStatus       = eStat_reg;
  assign wakeEdgeStatus      = wStat_reg;
  assign wakeMiscStatus      = mStat_reg;
  assign globalWakeStatus    = gStat_reg;
  assign routedIrqWakeStatus = route_reg;
  assign groupedMgmtIrq      = group_reg;
  assign serialIrq2          = sirq_reg;
  assign mgmtIrqPinOut       = irqPinOut_reg;
  assign mgmtIrqPinOe        = irqPinOe_reg;
  assign wakeEventPinOut     = wakPinOut_reg;
  assign wakeEventPinOe      = wakPinOe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sIrqGated;
    clkEn && !irqEnableTwo[SEA_EN2_PIN];
  endsequence

  // Inactive level the interrupt pin should show one edge later
  logic irqPinGpioCtrl_d;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irqPinGpioCtrl_d <= 1'b1;
    else if (clkEn)
      irqPinGpioCtrl_d <= ~irqPinGpioCtrl[SEA_CTRL_POL];
  end

  a_irq_pin_gate: assert property (sIrqGated |=> mgmtIrqPinOut == irqPinGpioCtrl_d)
    else $error("Interrupt pin active while pin routing disabled");

  a_wake_global_off: assert property (clkEn && !globalWakeEnable
      |=> wakeEventPinOut == !$past(wakePinGpioCtrl[SEA_CTRL_POL]))
    else $error("Wake pin active while global enable clear");

  a_od_release: assert property (clkEn && !irqPinGpioCtrl[SEA_CTRL_BUF] && !irqPinGpioCtrl[SEA_CTRL_POL]
      && !irqActive |=> !mgmtIrqPinOe)
    else $error("Open-drain pin misdriven");

  a_od_high_off: assert property (clkEn && !irqPinGpioCtrl[SEA_CTRL_BUF] && irqPinOut_next
      |=> !mgmtIrqPinOe)
    else $error("Open-drain pin drives high");

  a_edge_sticky: assert property (clkEn && |irqHit && !(|(irqHit & irqEdgeStatusClear))
      |=> |(irqEdgeStatus & $past(irqHit)))
    else $error("Interrupt edge status lost");

  a_w0_keeps: assert property (clkEn && irqEdgeStatusClear == '0
      |=> (irqEdgeStatus & $past(irqEdgeStatus)) == $past(irqEdgeStatus))
    else $error("Status cleared without a written one");

  a_wake_sticky: assert property (clkEn && wakeEdgeStatusClear == '0
      |=> (wakeEdgeStatus & $past(wakeEdgeStatus)) == $past(wakeEdgeStatus))
    else $error("Wake status cleared without a written one");

  a_gstat_pending: assert property (clkEn && |(wStat_next & wakeEdgeEnable)
      |=> globalWakeStatus)
    else $error("Global wake status clear with pending event");

  a_sirq_slot: assert property (clkEn |=> serialIrq2 ==
      ($past(groupComb) && $past(irqEnableTwo[SEA_EN2_SIRQ])))
    else $error("Serial IRQ2 slot mismatch");

  a_route_gate: assert property (clkEn && !route_reg && !irqEnableTwo[SEA_EN2_WAKE]
      |=> !routedIrqWakeStatus)
    else $error("Routed status set while routing disabled");

  // Event capture and pin drive checks
  a_periph_direct: assert property (clkEn
      && |(periphIrq[SEA_IR_IDX-1:0] & periphIrqEnable[SEA_IR_IDX-1:0]) |=> groupedMgmtIrq)
    else $error("Enabled peripheral event not grouped");

  a_ir_read_clear: assert property (clkEn && deviceIrqStatusTwoRead
      && !(periphIrq[SEA_IR_IDX] && !irRaw_reg) |=> !periphIrqStatus[SEA_IR_IDX])
    else $error("Infrared status not cleared by read");

  a_edge_group: assert property (clkEn && |(irqEdgeStatus & irqEdgeEnable)
      |=> groupedMgmtIrq)
    else $error("Enabled edge status not grouped");

  a_route_set: assert property (clkEn && groupComb && irqEnableTwo[SEA_EN2_WAKE]
      |=> routedIrqWakeStatus)
    else $error("Routed status missed the group");

  a_gstat_set: assert property (clkEn && |(wakeHit & wakeEdgeEnable)
      |=> globalWakeStatus)
    else $error("Global wake status missed an enabled edge");

  a_misc_set: assert property (clkEn && |wakeMiscEvent
      |=> |(wakeMiscStatus & $past(wakeMiscEvent)))
    else $error("Wake event pulse lost");

  a_irq_pp_drive: assert property (clkEn && irqPinGpioCtrl[SEA_CTRL_BUF]
      |=> mgmtIrqPinOe)
    else $error("Push-pull interrupt pin not driven");

  a_wake_pp_drive: assert property (clkEn && wakePinGpioCtrl[SEA_CTRL_BUF]
      |=> wakeEventPinOe)
    else $error("Push-pull wake pin not driven");

  a_wake_route: assert property (clkEn && globalWakeEnable && routedIrqWakeEnable
      && routedIrqWakeStatus && !routedIrqWakeStatusClear
      |=> wakeEventPinOut == $past(wakePinGpioCtrl[SEA_CTRL_POL]))
    else $error("Routed interrupt did not assert the wake pin");
endmodule : sea_smi_pme_aggregator

// ==== dv/sea_chipset_model.sv ====
// Chipset side model: pulled-up pin wires and active-level decode
`timescale 1ns/1ps
module sea_chipset_model (
  // Management interrupt pin
  input  wire logic mgmtIrqPinOut,
  input  wire logic mgmtIrqPinOe,
  input  wire logic mgmtActiveHigh,
  // Wake event pin
  input  wire logic wakeEventPinOut,
  input  wire logic wakeEventPinOe,
  input  wire logic wakeActiveHigh,
  // Resolved wires and decoded requests
  output logic      mgmtIrqLine,
  output logic      wakeEventLine,
  output logic      mgmtIrqSeen,
  output logic      wakeEventSeen
);
  //////////////////////////////////////////////////////////////////////////////
  // Board pull-ups hold released wires high, so a stray release reads inactive
  // only for active-low setups; active-high open-drain is a board error
  assign mgmtIrqLine   = mgmtIrqPinOe ? mgmtIrqPinOut : 1'b1;
  assign wakeEventLine = wakeEventPinOe ? wakeEventPinOut : 1'b1;
  // Chipset decodes the request with the polarity it was set up for
  assign mgmtIrqSeen   = mgmtIrqLine ~^ mgmtActiveHigh;
  assign wakeEventSeen = wakeEventLine ~^ wakeActiveHigh;
endmodule : sea_chipset_model

// ==== dv/testbench.sv ====
// Self-checking bench for the interrupt and wake aggregator
`timescale 1ns/1ps
module testbench;
  import sea_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  // Drive and observe
  logic                      clk, rst, clkEn, deviceIrqStatusTwoRead, globalWakeEnable;
  logic                      routedIrqWakeEnable, routedIrqWakeStatusClear, globalWakeStatus;
  logic                      routedIrqWakeStatus, groupedMgmtIrq, serialIrq2, mgmtIrqPinOut, mgmtIrqPinOe;
  logic                      wakeEventPinOut, wakeEventPinOe, mgmtIrqSeen, wakeEventSeen;
  logic [SEA_NUM_PERIPH-1:0] periphIrq, periphIrqEnable, periphIrqStatus;
  logic [SEA_NUM_EDGE-1:0]   irqEdgePin, irqEdgeInvert, irqDualEdgeEvent, irqEdgeEnable;
  logic [SEA_NUM_EDGE-1:0]   irqEdgeStatusClear, irqEdgeStatus;
  logic [SEA_NUM_WAKE-1:0]   wakeEdgePin, wakeEdgeInvert, wakeDualEdgeEvent, wakeEdgeEnable;
  logic [SEA_NUM_WAKE-1:0]   wakeEdgeStatusClear, wakeEdgeStatus;
  logic [SEA_NUM_MISC-1:0]   wakeMiscEvent, wakeMiscEnable, wakeMiscStatusClear, wakeMiscStatus;
  logic [7:0]                irqEnableTwo, irqPinGpioCtrl, wakePinGpioCtrl;
  int                        badCount, compares, cycles;
  //////////////////////////////////////////////////////////////////////////////
  // Design and chipset model
  sea_smi_pme_aggregator u_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .periphIrq(periphIrq),
    .periphIrqEnable(periphIrqEnable), .deviceIrqStatusTwoRead(deviceIrqStatusTwoRead),
    .irqEdgePin(irqEdgePin), .irqEdgeInvert(irqEdgeInvert), .irqDualEdgeEvent(irqDualEdgeEvent),
    .irqEdgeEnable(irqEdgeEnable), .irqEdgeStatusClear(irqEdgeStatusClear), .irqEnableTwo(irqEnableTwo),
    .wakeEdgePin(wakeEdgePin), .wakeEdgeInvert(wakeEdgeInvert), .wakeDualEdgeEvent(wakeDualEdgeEvent),
    .wakeEdgeEnable(wakeEdgeEnable), .wakeEdgeStatusClear(wakeEdgeStatusClear),
    .wakeMiscEvent(wakeMiscEvent), .wakeMiscEnable(wakeMiscEnable), .wakeMiscStatusClear(wakeMiscStatusClear),
    .globalWakeEnable(globalWakeEnable), .routedIrqWakeEnable(routedIrqWakeEnable),
    .routedIrqWakeStatusClear(routedIrqWakeStatusClear), .irqPinGpioCtrl(irqPinGpioCtrl),
    .wakePinGpioCtrl(wakePinGpioCtrl), .periphIrqStatus(periphIrqStatus), .irqEdgeStatus(irqEdgeStatus),
    .wakeEdgeStatus(wakeEdgeStatus), .wakeMiscStatus(wakeMiscStatus), .globalWakeStatus(globalWakeStatus),
    .routedIrqWakeStatus(routedIrqWakeStatus), .groupedMgmtIrq(groupedMgmtIrq), .serialIrq2(serialIrq2),
    .mgmtIrqPinOut(mgmtIrqPinOut), .mgmtIrqPinOe(mgmtIrqPinOe), .wakeEventPinOut(wakeEventPinOut),
    .wakeEventPinOe(wakeEventPinOe));
  sea_chipset_model u_chipset (.mgmtIrqPinOut(mgmtIrqPinOut), .mgmtIrqPinOe(mgmtIrqPinOe),
    .mgmtActiveHigh(irqPinGpioCtrl[SEA_CTRL_POL]), .wakeEventPinOut(wakeEventPinOut),
    .wakeEventPinOe(wakeEventPinOe), .wakeActiveHigh(wakePinGpioCtrl[SEA_CTRL_POL]),
    .mgmtIrqLine(), .wakeEventLine(), .mgmtIrqSeen(mgmtIrqSeen), .wakeEventSeen(wakeEventSeen));
  //////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling well above the expected run of about 1000 cycles
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      badCount++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Tasks: stimulus lands 1 ns after the edge so sampling never races it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic checkVal(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkVal
  task automatic checkPin(input logic seen, input logic oe, input logic expSeen, input logic expOe);
    checkVal({seen, oe}, {expSeen, expOe});
  endtask : checkPin
  task automatic irqClear(input logic [SEA_NUM_EDGE-1:0] m);
    irqEdgeStatusClear = m;
    tick(1);
    irqEdgeStatusClear = '0;
    tick(1);
  endtask : irqClear
  task automatic wakeClear(input logic [SEA_NUM_WAKE-1:0] m);
    wakeEdgeStatusClear = m;
    tick(1);
    wakeEdgeStatusClear = '0;
    tick(1);
  endtask : wakeClear
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {periphIrq, periphIrqEnable, deviceIrqStatusTwoRead, irqEdgePin, irqEdgeInvert, irqDualEdgeEvent} = '0;
    {irqEdgeEnable, irqEdgeStatusClear, irqEnableTwo, wakeEdgePin, wakeEdgeInvert, wakeDualEdgeEvent} = '0;
    {wakeEdgeEnable, wakeEdgeStatusClear, wakeMiscEvent, wakeMiscEnable, wakeMiscStatusClear} = '0;
    {globalWakeEnable, routedIrqWakeEnable, routedIrqWakeStatusClear, badCount, compares, cycles} = '0;
    irqPinGpioCtrl = SEA_PIN_CTRL_RST;
    wakePinGpioCtrl = SEA_PIN_CTRL_RST;
    clkEn = 1'b1;
    rst = 1'b1;
    tick(16);
    rst = 1'b0;
    checkPin(mgmtIrqSeen, mgmtIrqPinOe, 0, 0);
    checkPin(wakeEventSeen, wakeEventPinOe, 0, 0);
    // Each non-infrared peripheral source alone, first masked then enabled
    irqEnableTwo = 8'h80;
    for (int i = 0; i < SEA_IR_IDX; i++)
    begin
      periphIrqEnable = ~(7'h01 << i);
      periphIrq = 7'h01 << i;
      tick(2);
      checkVal(groupedMgmtIrq, 0);
      checkVal(periphIrqStatus, 7'h01 << i);
      periphIrqEnable = 7'h7f;
      tick(2);
      checkPin(mgmtIrqSeen, mgmtIrqPinOe, 1, 1);
      periphIrq = '0;
      tick(2);
      checkVal(periphIrqStatus, 0);
      checkPin(mgmtIrqSeen, mgmtIrqPinOe, 0, 0);
    end
    // Routing bits and push-pull polarities
    periphIrq = 7'h01;
    irqEnableTwo = 8'h00;
    tick(3);
    checkVal({groupedMgmtIrq, serialIrq2, routedIrqWakeStatus}, 3'b100);
    checkPin(mgmtIrqSeen, mgmtIrqPinOe, 0, 0);
    irqEnableTwo = 8'hc0;
    irqPinGpioCtrl = 8'h82;
    tick(3);
    checkVal(serialIrq2, 1);
    checkVal({mgmtIrqPinOut, mgmtIrqPinOe}, 2'b11);
    periphIrq = '0;
    irqPinGpioCtrl = 8'h80;
    tick(3);
    checkVal({serialIrq2, mgmtIrqPinOut, mgmtIrqPinOe}, 3'b011);
    // Infrared status stays after the source drops until status two is read
    irqPinGpioCtrl = SEA_PIN_CTRL_RST;
    periphIrq = 7'h40;
    tick(2);
    periphIrq = '0;
    tick(2);
    checkVal(periphIrqStatus, 7'h40);
    deviceIrqStatusTwoRead = 1'b1;
    tick(1);
    deviceIrqStatusTwoRead = 1'b0;
    tick(1);
    checkVal(periphIrqStatus, 0);
    // Every GPIO and tach interrupt edge, with write-zero and write-one clears
    irqEdgeEnable = '1;
    for (int e = 0; e < SEA_NUM_EDGE; e++)
    begin
      irqEdgePin[e] = 1'b1;
      tick(6);
      checkVal(irqEdgeStatus, 64'h1 << e);
      checkPin(mgmtIrqSeen, mgmtIrqPinOe, 1, 1);
      irqEdgePin[e] = 1'b0;
      tick(6);
      irqClear(~SEA_NUM_EDGE'(64'h1 << e));
      checkVal(irqEdgeStatus, 64'h1 << e);
      irqClear(SEA_NUM_EDGE'(64'h1 << e));
      tick(1);
      checkVal({irqEdgeStatus, groupedMgmtIrq}, 0);
    end
    // Inverted polarity sets on the fall only; masked status stays out of the group
    irqEdgeEnable = '0;
    irqEdgeInvert[0] = 1'b1;
    irqEdgePin[0] = 1'b1;
    tick(6);
    checkVal(irqEdgeStatus, 0);
    irqEdgePin[0] = 1'b0;
    tick(6);
    checkVal({irqEdgeStatus, groupedMgmtIrq}, 2'b10);
    irqClear(21'h1);
    irqDualEdgeEvent[0] = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      irqEdgePin[0] = ~irqEdgePin[0];
      tick(6);
      checkVal(irqEdgeStatus, 1);
      irqClear(21'h1);
    end
    // Every wake edge, tach included: status regardless of global enable
    wakeEdgeEnable = '1;
    for (int w = 0; w < SEA_NUM_WAKE; w++)
    begin
      globalWakeEnable = 1'b0;
      wakeEdgePin[w] = 1'b1;
      tick(6);
      checkVal(wakeEdgeStatus, 64'h1 << w);
      checkVal(globalWakeStatus, 1);
      checkPin(wakeEventSeen, wakeEventPinOe, 0, 0);
      globalWakeEnable = 1'b1;
      tick(2);
      checkPin(wakeEventSeen, wakeEventPinOe, 1, 1);
      wakeEdgePin[w] = 1'b0;
      wakeClear(~SEA_NUM_WAKE'(64'h1 << w));
      checkVal(globalWakeStatus, 1);
      wakeClear(SEA_NUM_WAKE'(64'h1 << w));
      tick(2);
      checkVal({wakeEdgeStatus, globalWakeStatus}, 0);
      checkPin(wakeEventSeen, wakeEventPinOe, 0, 0);
    end
    // Wake dual edge and inverted polarity
    wakeDualEdgeEvent[0] = 1'b1;
    wakeEdgeInvert[1] = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wakeEdgePin[1:0] = ~wakeEdgePin[1:0];
      tick(6);
      checkVal(wakeEdgeStatus, k ? 33'h3 : 33'h1);
      wakeClear('1);
    end
    // Ring, infrared frame and keyboard/mouse event pulses
    wakeMiscEnable = '1;
    for (int m = 0; m < SEA_NUM_MISC; m++)
    begin
      wakeMiscEvent = 4'h1 << m;
      tick(1);
      wakeMiscEvent = '0;
      tick(3);
      checkVal({wakeMiscStatus, globalWakeStatus}, {4'h1 << m, 1'b1});
      wakeMiscStatusClear = '1;
      tick(1);
      wakeMiscStatusClear = '0;
      tick(2);
      checkVal({wakeMiscStatus, globalWakeStatus}, 0);
    end
    // Grouped interrupt routed into the wake pin, active-high push-pull
    irqEnableTwo = 8'h20;
    wakePinGpioCtrl = 8'h82;
    routedIrqWakeEnable = 1'b1;
    periphIrq = 7'h01;
    tick(4);
    checkVal(routedIrqWakeStatus, 1);
    checkVal({wakeEventPinOut, wakeEventPinOe}, 2'b11);
    routedIrqWakeEnable = 1'b0;
    periphIrq = '0;
    tick(4);
    checkVal(routedIrqWakeStatus, 1);
    checkVal({wakeEventPinOut, wakeEventPinOe}, 2'b01);
    routedIrqWakeStatusClear = 1'b1;
    tick(1);
    routedIrqWakeStatusClear = 1'b0;
    tick(1);
    checkVal(routedIrqWakeStatus, 0);
    summarize();
  end
endmodule : testbench
